/* rtl/cmc_monitor.sv */
// cmc_monitor: checks configuration memory against a crc taken at load
// assumes CFG_* words arrive during configuration and the cell array
// answers CELL_ADDR with CELL_DATA one cycle later
// Behaviour
// - 32-bit crc result and reference value
// - compute reference crc during configuration load
// - recompute over cells in user mode, compare
// - mismatch asserts the error output pin
// - repeat cell check pass after pass
// - checker clock from built-in divider
// - checker rate 400 khz to 50 mhz
// - option disables checking and the raising of new errors
`timescale 1ns/1ps
module cmc_monitor
  import cmc_pkg::*;
(
  input  wire logic                MCLK,
  input  wire logic                NRST,
  input  wire logic                CFG_START,
  input  wire logic                CFG_VALID,
  input  wire logic [31:0]         CFG_DATA,
  input  wire logic                CFG_DONE,
  input  wire logic                CHK_ENABLE,
  input  wire logic [DIV_W-1:0]    CHK_DIV,
  output logic      [ADDR_W-1:0]   CELL_ADDR,
  input  wire logic [31:0]         CELL_DATA,
  output logic                     USER_MODE,
  output logic                     CRC_FAULT,
  output logic      [CRC_W-1:0]    REF_CRC
);
  import cmc_pkg::*;

  cmc_state_t        state_q;
  logic [31:0]       ref_q;
  logic [31:0]       run_q;
  logic [31:0]       crc_step;
  logic [31:0]       crc_src;
  logic [31:0]       word_in;
  logic [ADDR_W-1:0] addr_q;
  logic [DIV_W-1:0]  div_cnt_q;
  logic [DIV_W-1:0]  div_lim;
  logic              tick;
  logic              rd_pend_q;
  logic              last_q;
  logic              err_q;

  assign crc_src = (state_q == CMC_LOAD) ? ref_q : run_q;
  assign word_in = (state_q == CMC_LOAD) ? CFG_DATA : CELL_DATA;

  cmc_crc32 u_crc (
    .crc_in  (crc_src),
    .data    (word_in),
    .crc_out (crc_step)
  );

  // out-of-range settings are clamped so the rate stays in band
  always_comb
  begin
    if (CHK_DIV < DIV_W'(DIV_MIN))
      div_lim = DIV_W'(DIV_MIN);
    else if (CHK_DIV > DIV_W'(DIV_MAX))
      div_lim = DIV_W'(DIV_MAX);
    else
      div_lim = CHK_DIV;
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      div_cnt_q <= DIV_RST;
    else if (state_q != CMC_SCAN || div_cnt_q >= div_lim - 10'h001)
      div_cnt_q <= 10'h000;
    else
      div_cnt_q <= div_cnt_q + 10'h001;
  end

  assign tick = (state_q == CMC_SCAN) && CHK_ENABLE &&
                (div_cnt_q >= div_lim - 10'h001);

  // state sequencing
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      state_q <= CMC_IDLE;
    else if (CFG_START)
      state_q <= CMC_LOAD;
    else
    begin
      unique case (state_q)
        CMC_IDLE:
          state_q <= CMC_IDLE;
        CMC_LOAD:
          if (CFG_DONE && !CFG_VALID)
            state_q <= CMC_SCAN;
        CMC_SCAN:
          if (rd_pend_q && last_q)
            state_q <= CMC_CMP;
        CMC_CMP:
          state_q <= CMC_SCAN;
      endcase
    end
  end

  // reference crc taken over the configuration stream
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      ref_q <= CRC_INIT;
    else if (CFG_START)
      ref_q <= CRC_INIT;
    else if (state_q == CMC_LOAD && CFG_VALID)
      ref_q <= crc_step;
  end

  // cell scan: one address per divider tick, data seen a cycle later
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      addr_q    <= 8'h00;
      rd_pend_q <= 1'b0;
      last_q    <= 1'b0;
    end
    else if (state_q != CMC_SCAN)
    begin
      addr_q    <= 8'h00;
      rd_pend_q <= 1'b0;
      last_q    <= 1'b0;
    end
    else
    begin
      rd_pend_q <= tick;
      if (tick)
      begin
        last_q <= (addr_q == LAST_ADDR);
        addr_q <= addr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      run_q <= CRC_INIT;
    else if (state_q != CMC_SCAN)
      run_q <= CRC_INIT;
    else if (rd_pend_q && !last_q)
      run_q <= crc_step;
    else if (rd_pend_q && last_q)
      run_q <= crc_step;
  end

  // sticky error; only reset or a new configuration clears it
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      err_q <= 1'b0;
    else if (state_q == CMC_CMP && CHK_ENABLE && run_q != ref_q)
      err_q <= 1'b1;
    else if (CFG_START)
      err_q <= 1'b0;
  end

  assign CELL_ADDR = addr_q;
  assign USER_MODE = (state_q == CMC_SCAN) || (state_q == CMC_CMP);
  assign CRC_FAULT = err_q;
  assign REF_CRC   = ref_q;

  property p_fault_on_mismatch;
    @(posedge MCLK) disable iff (!NRST)
      (state_q == CMC_CMP && CHK_ENABLE && run_q != ref_q)
        |=> CRC_FAULT;
  endproperty
  a_fault_on_mismatch: assert property (p_fault_on_mismatch)
    else $error("mismatch did not raise fault");

  property p_fault_sticky;
    @(posedge MCLK) disable iff (!NRST)
      (CRC_FAULT && !CFG_START) |=> CRC_FAULT;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault dropped without reconfiguration");

  property p_no_rise_disabled;
    @(posedge MCLK) disable iff (!NRST)
      (!CHK_ENABLE && !CRC_FAULT) |=> !CRC_FAULT;
  endproperty
  a_no_rise_disabled: assert property (p_no_rise_disabled)
    else $error("fault raised while checking disabled");

  property p_no_tick_disabled;
    @(posedge MCLK) disable iff (!NRST)
      !CHK_ENABLE |-> !tick;
  endproperty
  a_no_tick_disabled: assert property (p_no_tick_disabled)
    else $error("cell read while checking disabled");

  property p_tick_spacing;
    @(posedge MCLK) disable iff (!NRST)
      tick |=> !tick [*4];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("checker rate above upper bound");

  property p_div_bound;
    @(posedge MCLK) disable iff (!NRST)
      div_cnt_q < 10'(DIV_MAX);
  endproperty
  a_div_bound: assert property (p_div_bound)
    else $error("divider count out of range");

  property p_pass_repeats;
    @(posedge MCLK) disable iff (!NRST)
      (state_q == CMC_CMP && !CFG_START) |=>
        (state_q == CMC_SCAN && run_q == CRC_INIT && CELL_ADDR == 8'h00);
  endproperty
  a_pass_repeats: assert property (p_pass_repeats)
    else $error("scan pass did not restart");

  property p_ref_frozen;
    @(posedge MCLK) disable iff (!NRST)
      (USER_MODE && !CFG_START) |=> $stable(REF_CRC);
  endproperty
  a_ref_frozen: assert property (p_ref_frozen)
    else $error("reference changed in user mode");

  property p_addr_advance;
    @(posedge MCLK) disable iff (!NRST)
      (tick && !CFG_START) |=> (CELL_ADDR == $past(CELL_ADDR) + 8'h01);
  endproperty
  a_addr_advance: assert property (p_addr_advance)
    else $error("cell address did not advance");
endmodule

/* rtl/cmc_pkg.sv */
// cmc_pkg: constants shared by the configuration memory crc monitor
// assumes a single 250 mhz clock domain
package cmc_pkg;
  localparam int          CRC_W        = 32;
  localparam logic [31:0] CRC_POLY     = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT     = 32'hffffffff;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  LAST_ADDR    = 8'hff;
  localparam int          MCLK_KHZ     = 250000;
  localparam int          CHK_MIN_KHZ  = 400;
  localparam int          CHK_MAX_KHZ  = 50000;
  // divider bounds in mclk cycles per checker tick
  localparam int          DIV_MIN      = (MCLK_KHZ + CHK_MAX_KHZ - 1)
                                         / CHK_MAX_KHZ;
  localparam int          DIV_MAX      = MCLK_KHZ / CHK_MIN_KHZ;
  localparam int          DIV_W        = 10;
  localparam logic [9:0]  DIV_RST      = 10'(DIV_MIN);
  typedef enum logic [1:0] {
    CMC_IDLE  = 2'b00,
    CMC_LOAD  = 2'b01,
    CMC_SCAN  = 2'b11,
    CMC_CMP   = 2'b10
  } cmc_state_t;
endpackage

/* rtl/cmc_crc32.sv */
// cmc_crc32: one-word combinational crc-32 step
// assumes the caller holds the running value in a register
`timescale 1ns/1ps
module cmc_crc32
  import cmc_pkg::*;
(
  input  wire logic [31:0] crc_in,
  input  wire logic [31:0] data,
  output logic      [31:0] crc_out
);
  always_comb
  begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 31; i >= 0; i--)
    begin
      if (c[31] ^ data[i])
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[30:0], 1'b0};
    end
    crc_out = c;
  end
endmodule

/* testbench/cmc_cell_model.sv */
// cmc_cell_model: config cell array and supervisor on the fault pin
// assumes the bench writes cells while it loads config words
`timescale 1ns/1ps
module cmc_cell_model (
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [7:0]  wa,
  input  wire logic [31:0] wd,
  input  wire logic [7:0]  addr,
  input  wire logic        fault,
  output logic      [31:0] data,
  output logic             reconf_req
);
  logic [31:0] mem [256];
  // registered read: the word for the address held before a tick is
  // what the monitor consumes on the edge after that tick
  always_ff @(posedge clk)
  begin
    if (we)
      mem[wa] <= wd;
    data       <= mem[addr];
    reconf_req <= fault;
  end
endmodule

/* testbench/cmc_monitor_tb.sv */
// cmc_monitor_tb: self-checking bench for the crc monitor
// assumes the cell model answers CELL_ADDR one cycle later
`timescale 1ns/1ps
module cmc_monitor_tb;
  import cmc_pkg::*;
  logic MCLK = 0, NRST = 0, CFG_START = 0, CFG_VALID = 0, CFG_DONE = 0;
  logic CHK_ENABLE = 1, we = 0, USER_MODE, CRC_FAULT, req;
  logic [DIV_W-1:0] CHK_DIV = 10'h005;
  logic [31:0] CFG_DATA = 0, CELL_DATA, REF_CRC, wd = 0, crc, w;
  logic [7:0] CELL_ADDR, wa = 0;
  logic [31:0] exp_q[$], got_q[$];
  string nm_q[$];
  int num_errors = 0, compares = 0, n;
  cmc_monitor cmc_monitor_i (.MCLK(MCLK), .NRST(NRST),
    .CFG_START(CFG_START), .CFG_VALID(CFG_VALID), .CFG_DATA(CFG_DATA),
    .CFG_DONE(CFG_DONE), .CHK_ENABLE(CHK_ENABLE), .CHK_DIV(CHK_DIV),
    .CELL_ADDR(CELL_ADDR), .CELL_DATA(CELL_DATA),
    .USER_MODE(USER_MODE), .CRC_FAULT(CRC_FAULT), .REF_CRC(REF_CRC));
  cmc_cell_model cmc_cell_model_i (.clk(MCLK), .we(we), .wa(wa),
    .wd(wd), .addr(CELL_ADDR), .fault(CRC_FAULT), .data(CELL_DATA),
    .reconf_req(req));
  initial forever #2 MCLK = ~MCLK;
  task automatic cyc(int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  task automatic note(string s, logic [31:0] e, logic [31:0] g);
    nm_q.push_back(s);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  // results are compared off the driving edge, oldest note first
  always @(negedge MCLK)
    while (got_q.size() > 0)
    begin
      compares++;
      if (got_q[0] !== exp_q[0])
      begin
        num_errors++;
        $display("CHECK FAILED %s exp %h got %h", nm_q[0], exp_q[0],
                 got_q[0]);
      end
      void'(nm_q.pop_front());
      void'(exp_q.pop_front());
      void'(got_q.pop_front());
    end
  task automatic configure();
    crc = CRC_INIT;
    CFG_START = 1;
    cyc(1);
    CFG_START = 0;
    CFG_VALID = 1;
    we = 1;
    for (int i = 0; i < 256; i++)
    begin
      w = $urandom;
      CFG_DATA = w;
      wa = i[7:0];
      wd = w;
      for (int b = 31; b >= 0; b--)
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ w[b]) ? CRC_POLY : 32'h0);
      cyc(1);
    end
    CFG_VALID = 0;
    we = 0;
    CFG_DONE = 1;
    cyc(1);
    CFG_DONE = 0;
    cyc(1);
    note("REF_CRC", crc, REF_CRC);
    note("USER_MODE", 1, USER_MODE);
  endtask
  task automatic wait_fault(int lim);
    n = 0;
    while (CRC_FAULT !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  // first gaps may straddle the divider change, so time the third
  task automatic tick_gap(logic [9:0] d, int e);
    CHK_DIV = d;
    for (int k = 0; k < 3; k++)
    begin
      w = {24'h0, CELL_ADDR};
      n = 0;
      while (CELL_ADDR === w[7:0] && n < 2000)
      begin
        cyc(1);
        n++;
      end
    end
    note("tick gap", e, n);
  endtask
  task automatic flip_cell();
    we = 1;
    wa = 8'h10;
    wd = ~cmc_cell_model_i.mem[16];
    cyc(1);
    we = 0;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    n = $urandom(60);
    cyc(12);
    note("REF_CRC rst", 32'hffffffff, REF_CRC);
    note("CRC_FAULT rst", 0, CRC_FAULT);
    NRST = 1;
    configure();
    wait_fault(3000);
    note("CRC_FAULT clean", 0, CRC_FAULT);
    tick_gap(10'h007, 7);
    tick_gap(10'h001, 5);
    tick_gap(10'h271, 625);
    CHK_DIV = 10'h005;
    flip_cell();
    wait_fault(3000);
    note("CRC_FAULT bad", 1, CRC_FAULT);
    flip_cell();
    cyc(3000);
    note("CRC_FAULT held", 1, CRC_FAULT);
    note("reconf req", 1, req);
    note("REF_CRC held", crc, REF_CRC);
    CHK_ENABLE = req ? 1'b0 : 1'b1;
    configure();
    flip_cell();
    wait_fault(3000);
    note("CRC_FAULT off", 0, CRC_FAULT);
    cyc(2);
    tally_and_finish();
  end
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
